// ### pkg/lgh_defs.vh
// register offsets, field positions, reset values and timing for the block
`ifndef LGH_DEFS_VH
`define LGH_DEFS_VH

// register offsets (byte index = printed offset, bus address = 4*index)
`define LGH_IDX_SHADOW_HI   6'h31
`define LGH_IDX_SHADOW_LO   6'h32
`define LGH_IDX_MISC_GAIN   6'h33
`define LGH_IDX_HS_POS_HI   6'h34
`define LGH_IDX_HS_BEGIN_LO 6'h35
`define LGH_IDX_HS_END_LO   6'h36
`define LGH_IDX_POLARITY    6'h37
`define LGH_IDX_GAIN_MODE   6'h38

// reset values
`define LGH_RST_SHADOW_HI   8'h70
`define LGH_RST_SHADOW_LO   8'h00
`define LGH_RST_MISC_GAIN   8'hE3
`define LGH_RST_HS_POS_HI   8'h0F
`define LGH_RST_HS_BEGIN_LO 8'h01
`define LGH_RST_HS_END_LO   8'h00
`define LGH_RST_POLARITY    8'h00
`define LGH_RST_GAIN_MODE   3'h0

// reserved bits forced to one on write
`define LGH_RSV1_SHADOW_HI  8'h70
`define LGH_RSV1_MISC_GAIN  8'hA0
`define LGH_RSV1_HS_POS_HI  8'h0F

// field positions
`define LGH_SURV_UPD_BIT    7
`define LGH_UPD_RATE_BIT    0
`define LGH_AVG_LINE_BIT    1
`define LGH_IRE_LSB         2
`define LGH_COLOUR_KILL_BIT 6
`define LGH_POL_CLK_BIT     0
`define LGH_POL_FIFO_BIT    1
`define LGH_POL_VS_BIT      5
`define LGH_POL_REF_BIT     6
`define LGH_POL_HS_BIT      7

// gain mode code for manual fixed gain
`define LGH_MODE_MANUAL     3'h0

// average brightness line windows
`define LGH_AVG_FIRST_LINE  9'd33
`define LGH_AVG_LAST_LONG   9'd310
`define LGH_AVG_LAST_SHORT  9'd270

// bus answer latency in clocks (one wait state)
`define LGH_BUS_WAIT        1

`endif

// ### verilog/lgh_hsync_gen.v
// programmable horizontal sync pulse placed relative to internal sync
`timescale 1ns/1ps
module lgh_hsync_gen (
	// clock and reset
	input  wire       i_sys_clk,
	input  wire       i_rstn,
	// timing
	input  wire       i_pix_en,       // one pulse per pixel
	input  wire       i_int_hsync,    // internal sync, falls at line start
	input  wire [9:0] i_begin_pos,    // start offset in pixels
	input  wire [9:0] i_end_pos,      // end offset in pixels
	// result
	output reg        o_hsync         // active-high sync pulse
);

	reg        int_hs_q;   // previous internal sync level
	reg  [9:0] pix_cnt_q;  // pixels since falling edge
	reg        run_q;      // counting after a falling edge
	wire       fall;       // falling edge of internal sync

	assign fall = int_hs_q & ~i_int_hsync;

	// count pixels from the falling edge and place the pulse
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			int_hs_q  <= 1'b0;
			pix_cnt_q <= 10'h000;
			run_q     <= 1'b0;
			o_hsync   <= 1'b0;
		end else begin
			int_hs_q <= i_int_hsync;
			if (fall) begin
				// restart; a zero begin offset asserts at the edge
				pix_cnt_q <= 10'h000;
				run_q     <= 1'b1;
				if (i_begin_pos == 10'h000)
					o_hsync <= 1'b1;
				if (i_end_pos == 10'h000)
					o_hsync <= 1'b0;
			end else if (run_q && i_pix_en) begin
				pix_cnt_q <= pix_cnt_q + 10'h001;
				if (pix_cnt_q + 10'h001 == i_begin_pos)
					o_hsync <= 1'b1;
				if (pix_cnt_q + 10'h001 == i_end_pos)
					o_hsync <= 1'b0;
				// stop at wrap so a stray count cannot retrigger
				if (pix_cnt_q == 10'h3FF)
					run_q <= 1'b0;
			end
		end
	end

endmodule // lgh_hsync_gen

// ### verilog/lgh_regs.v
// luma gain, sync position and output polarity registers on avalon-mm
`timescale 1ns/1ps
`include "lgh_defs.vh"

// Overview of operation
// - gain store written, reads last captured gain
// - stored gain used only in manual mode
// - bit 7 enables surveillance store updates
// - low byte in second shadow, high nibble first
// - bit 0: update gain per line or field
// - bit 1: brightness lines 33-310 or 33-270
// - ire codes 000-111 set max level
// - bit 6 switches colour kill on
// - sync ends end-value pixels after edge
// - sync starts begin-value pixels after edge
// - begin/end high bits in first register
// - bit 0 inverts the three clocks
// - bit 1 inverts the three fifo flags
// - bits 5,6,7 invert vsync, refs, hsync
// - gain mode 000 means manual fixed gain
// - sync registers reset to 0F, 01, 00
module lgh_regs (
	// clock and reset
	input  wire        i_sys_clk,
	input  wire        i_rstn,
	// avalon-mm slave
	input  wire [7:0]  i_avs_address,     // word address
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output reg  [31:0] o_avs_readdata,
	output wire        o_avs_waitrequest,
	// gain loop interface
	input  wire [11:0] i_agc_gain,        // gain chosen by automatic loop
	input  wire        i_line_start,      // pulse at each new line
	input  wire        i_field_start,     // pulse at each new field
	input  wire [8:0]  i_line_num,        // current line in field
	input  wire        i_pal,             // 1 = pal, 0 = ntsc
	output reg  [11:0] o_luma_gain,       // gain applied to luma path
	output reg         o_gain_update,     // gain loop update strobe
	output reg         o_avg_window,      // line inside brightness window
	output reg  [7:0]  o_max_ire,         // max input ire level
	output wire        o_colour_kill_en,
	output wire [2:0]  o_luma_gain_mode,
	// sync timing
	input  wire        i_pix_en,
	input  wire        i_int_hsync,
	// raw outputs from the video core
	input  wire        i_line_locked_clock,
	input  wire        i_line_locked_clock_half,
	input  wire        i_qualifier_clock,
	input  wire        i_fifo_half_full,
	input  wire        i_fifo_almost_empty,
	input  wire        i_fifo_almost_full,
	input  wire        i_pol2_src,
	input  wire        i_pol3_src,
	input  wire        i_pol4_src,
	input  wire        i_vsync,
	input  wire        i_horiz_reference,
	input  wire        i_vert_reference,
	// polarity-adjusted pins
	output wire        o_line_locked_clock,
	output wire        o_line_locked_clock_half,
	output wire        o_qualifier_clock,
	output wire        o_fifo_half_full,
	output wire        o_fifo_almost_empty,
	output wire        o_fifo_almost_full,
	output wire        o_pol2_out,
	output wire        o_pol3_out,
	output wire        o_pol4_out,
	output wire        o_vsync,
	output wire        o_horiz_reference,
	output wire        o_vert_reference,
	output wire        o_hsync
);

	// state of the bus slave
	localparam ST_IDLE = 1'b0;   // waiting for a request
	localparam ST_ACK  = 1'b1;   // answer given this cycle

	reg        st_q;             // bus state
	reg  [7:0] shadow_hi_q;      // surveillance enable and gain high nibble
	reg  [7:0] shadow_lo_q;      // gain low byte
	reg  [7:0] misc_gain_q;      // update rate, line window, ire, kill
	reg  [7:0] hs_pos_hi_q;      // begin/end high bits
	reg  [7:0] hs_begin_lo_q;    // begin low byte
	reg  [7:0] hs_end_lo_q;      // end low byte
	reg  [7:0] polarity_q;       // output polarity bits
	reg  [2:0] gain_mode_q;      // luma gain control mode
	reg  [11:0] held_gain_q;     // last gain captured for readback
	reg  [7:0] rd_byte;          // selected register value
	wire       req;              // a request is present
	wire       wr_lo_en;         // write with low lane enabled
	wire [11:0] manual_gain;     // gain programmed through shadows
	wire        manual_mode;     // manual fixed gain selected
	wire [9:0]  begin_pos;       // sync begin offset
	wire [9:0]  end_pos;         // sync end offset
	wire [2:0]  ire_code;        // max ire selection

	// true when the word address hits a given register index
	function hit;
		input [7:0] addr;
		input [5:0] idx;
		begin
			hit = (addr == {2'b00, idx});
		end
	endfunction

	// pick the pal or ntsc value of one ire table row
	function [7:0] ire_pick;
		input       pal;
		input [7:0] pal_v;
		input [7:0] ntsc_v;
		begin
			ire_pick = pal ? pal_v : ntsc_v;
		end
	endfunction

	assign req      = i_avs_read | i_avs_write;
	// writes land on the answering edge, where waitrequest is seen low
	assign wr_lo_en = i_avs_write & i_avs_byteenable[0] & (st_q == ST_ACK);
	// one wait state: request seen in idle, answered the next cycle
	assign o_avs_waitrequest = req & (st_q == ST_IDLE);

	assign manual_gain = {shadow_hi_q[3:0], shadow_lo_q};
	assign manual_mode = (gain_mode_q == `LGH_MODE_MANUAL);
	assign begin_pos   = {hs_pos_hi_q[7:6], hs_begin_lo_q};
	assign end_pos     = {hs_pos_hi_q[5:4], hs_end_lo_q};
	assign ire_code    = misc_gain_q[`LGH_IRE_LSB +: 3];
	assign o_colour_kill_en = misc_gain_q[`LGH_COLOUR_KILL_BIT];
	assign o_luma_gain_mode = gain_mode_q;

	// bus state machine
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (req)
						st_q <= ST_ACK;
				end
				ST_ACK: begin
					st_q <= ST_IDLE; // master drops or re-issues
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// register writes land with the answer, never on the waiting edge
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			shadow_hi_q   <= `LGH_RST_SHADOW_HI;
			shadow_lo_q   <= `LGH_RST_SHADOW_LO;
			misc_gain_q   <= `LGH_RST_MISC_GAIN;
			hs_pos_hi_q   <= `LGH_RST_HS_POS_HI;
			hs_begin_lo_q <= `LGH_RST_HS_BEGIN_LO;
			hs_end_lo_q   <= `LGH_RST_HS_END_LO;
			polarity_q    <= `LGH_RST_POLARITY;
			gain_mode_q   <= `LGH_RST_GAIN_MODE;
		end else if (wr_lo_en) begin
			// reserved bits are kept at one regardless of the write
			if (hit(i_avs_address, `LGH_IDX_SHADOW_HI))
				shadow_hi_q <= i_avs_writedata[7:0] | `LGH_RSV1_SHADOW_HI;
			if (hit(i_avs_address, `LGH_IDX_SHADOW_LO))
				shadow_lo_q <= i_avs_writedata[7:0];
			if (hit(i_avs_address, `LGH_IDX_MISC_GAIN))
				misc_gain_q <= i_avs_writedata[7:0] | `LGH_RSV1_MISC_GAIN;
			if (hit(i_avs_address, `LGH_IDX_HS_POS_HI))
				hs_pos_hi_q <= i_avs_writedata[7:0] | `LGH_RSV1_HS_POS_HI;
			if (hit(i_avs_address, `LGH_IDX_HS_BEGIN_LO))
				hs_begin_lo_q <= i_avs_writedata[7:0];
			if (hit(i_avs_address, `LGH_IDX_HS_END_LO))
				hs_end_lo_q <= i_avs_writedata[7:0];
			if (hit(i_avs_address, `LGH_IDX_POLARITY))
				polarity_q <= i_avs_writedata[7:0];
			if (hit(i_avs_address, `LGH_IDX_GAIN_MODE))
				gain_mode_q <= i_avs_writedata[2:0];
		end
	end

	// gain actually in use; manual mode loads the manual gain into the store, automatic gain is sampled
	// into it only when surveillance updates are on, else the store holds
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			held_gain_q <= 12'h000;
			o_luma_gain <= 12'h000;
		end else begin
			if (manual_mode) begin
				o_luma_gain <= manual_gain;
				held_gain_q <= manual_gain;
			end else begin
				o_luma_gain <= i_agc_gain;
				if (shadow_hi_q[`LGH_SURV_UPD_BIT])
					held_gain_q <= i_agc_gain;
			end
		end
	end

	// read mux; the gain store reads the last captured gain
	always @* begin
		rd_byte = 8'h00;
		if (hit(i_avs_address, `LGH_IDX_SHADOW_HI))
			rd_byte = {shadow_hi_q[7:4], held_gain_q[11:8]};
		else if (hit(i_avs_address, `LGH_IDX_SHADOW_LO))
			rd_byte = held_gain_q[7:0];
		else if (hit(i_avs_address, `LGH_IDX_MISC_GAIN))
			rd_byte = misc_gain_q;
		else if (hit(i_avs_address, `LGH_IDX_HS_POS_HI))
			rd_byte = hs_pos_hi_q;
		else if (hit(i_avs_address, `LGH_IDX_HS_BEGIN_LO))
			rd_byte = hs_begin_lo_q;
		else if (hit(i_avs_address, `LGH_IDX_HS_END_LO))
			rd_byte = hs_end_lo_q;
		else if (hit(i_avs_address, `LGH_IDX_POLARITY))
			rd_byte = polarity_q;
		else if (hit(i_avs_address, `LGH_IDX_GAIN_MODE))
			rd_byte = {5'b00000, gain_mode_q};
		else
			rd_byte = 8'h00; // unmapped reads as zero
	end

	// read data registered on the waiting cycle, stands at the answer
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_avs_read && st_q == ST_IDLE)
			o_avs_readdata <= {24'h00_0000, rd_byte};
	end

	// gain update strobe and brightness window
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_gain_update <= 1'b0;
			o_avg_window  <= 1'b0;
		end else begin
			if (misc_gain_q[`LGH_UPD_RATE_BIT])
				o_gain_update <= i_field_start;
			else
				o_gain_update <= i_line_start;
			if (misc_gain_q[`LGH_AVG_LINE_BIT])
				o_avg_window <= (i_line_num >= `LGH_AVG_FIRST_LINE) &&
					(i_line_num <= `LGH_AVG_LAST_SHORT);
			else
				o_avg_window <= (i_line_num >= `LGH_AVG_FIRST_LINE) &&
					(i_line_num <= `LGH_AVG_LAST_LONG);
		end
	end

	// max ire level per code and video standard
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_max_ire <= 8'd133;
		end else begin
			case (ire_code)
				3'b000: o_max_ire <= ire_pick(i_pal, 8'd133, 8'd122);
				3'b001: o_max_ire <= ire_pick(i_pal, 8'd125, 8'd115);
				3'b010: o_max_ire <= ire_pick(i_pal, 8'd120, 8'd110);
				3'b011: o_max_ire <= ire_pick(i_pal, 8'd115, 8'd105);
				3'b100: o_max_ire <= ire_pick(i_pal, 8'd110, 8'd100);
				3'b101: o_max_ire <= ire_pick(i_pal, 8'd105, 8'd100);
				default: o_max_ire <= 8'd100;
			endcase
		end
	end

	// polarity: xor keeps clocks glitch-free only if bits change rarely
	assign o_line_locked_clock      = i_line_locked_clock ^
		polarity_q[`LGH_POL_CLK_BIT];
	assign o_line_locked_clock_half = i_line_locked_clock_half ^
		polarity_q[`LGH_POL_CLK_BIT];
	assign o_qualifier_clock        = i_qualifier_clock ^
		polarity_q[`LGH_POL_CLK_BIT];
	assign o_fifo_half_full    = i_fifo_half_full ^
		polarity_q[`LGH_POL_FIFO_BIT];
	assign o_fifo_almost_empty = i_fifo_almost_empty ^
		polarity_q[`LGH_POL_FIFO_BIT];
	assign o_fifo_almost_full  = i_fifo_almost_full ^
		polarity_q[`LGH_POL_FIFO_BIT];
	assign o_pol2_out = i_pol2_src ^ polarity_q[2];
	assign o_pol3_out = i_pol3_src ^ polarity_q[3];
	assign o_pol4_out = i_pol4_src ^ polarity_q[4];
	assign o_vsync    = i_vsync ^ polarity_q[`LGH_POL_VS_BIT];
	assign o_horiz_reference = i_horiz_reference ^
		polarity_q[`LGH_POL_REF_BIT];
	assign o_vert_reference  = i_vert_reference ^
		polarity_q[`LGH_POL_REF_BIT];

	wire hsync_raw;  // positioned sync before polarity

	// positioned horizontal sync
	lgh_hsync_gen u_hsync (
		.i_sys_clk   (i_sys_clk),
		.i_rstn      (i_rstn),
		.i_pix_en    (i_pix_en),
		.i_int_hsync (i_int_hsync),
		.i_begin_pos (begin_pos),
		.i_end_pos   (end_pos),
		.o_hsync     (hsync_raw)
	);

	assign o_hsync = hsync_raw ^ polarity_q[`LGH_POL_HS_BIT];

endmodule // lgh_regs

// ### verif/lgh_regs_properties.sv
// port-level checks for the gain and polarity registers
`timescale 1ns/1ps
module lgh_regs_props (
	// clock and reset
	input wire        i_sys_clk,
	input wire        i_rstn,
	// avalon-mm
	input wire        i_avs_read,
	input wire        i_avs_write,
	input wire [31:0] o_avs_readdata,
	input wire        o_avs_waitrequest,
	// gain loop
	input wire        i_line_start,
	input wire        i_field_start,
	input wire [8:0]  i_line_num,
	input wire        o_gain_update,
	input wire        o_avg_window,
	input wire [7:0]  o_max_ire,
	input wire        o_colour_kill_en,
	input wire [2:0]  o_luma_gain_mode,
	// polarity pins
	input wire        i_line_locked_clock,
	input wire        o_line_locked_clock,
	input wire        i_line_locked_clock_half,
	input wire        o_line_locked_clock_half,
	input wire        i_qualifier_clock,
	input wire        o_qualifier_clock,
	input wire        i_horiz_reference,
	input wire        o_horiz_reference,
	input wire        i_vert_reference,
	input wire        o_vert_reference
);
	// inversion seen on each pin; one bit drives a whole group
	wire inv_llc  = o_line_locked_clock ^ i_line_locked_clock;
	wire inv_line_locked_clock_half = o_line_locked_clock_half ^ i_line_locked_clock_half;
	wire inv_qualifier_clock = o_qualifier_clock ^ i_qualifier_clock;
	wire inv_horiz_reference = o_horiz_reference ^ i_horiz_reference;
	wire inv_vref = o_vert_reference ^ i_vert_reference;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	bus_answer_a: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("no answer after one wait");
	rdata_upper_a: assert property (
		o_avs_readdata[31:8] == 24'h0) else $error("readdata upper nonzero");
	ire_set_a: assert property (o_max_ire inside {8'h64, 8'h69,
		8'h6E, 8'h73, 8'h78, 8'h7D, 8'h7A, 8'h85})
		else $error("max ire outside table");
	upd_cause_a: assert property (o_gain_update |->
		$past(i_line_start) || $past(i_field_start))
		else $error("gain update without line or field start");
	avg_window_a: assert property (o_avg_window |->
		$past(i_line_num) >= 9'h021 && $past(i_line_num) <= 9'h136)
		else $error("brightness window outside lines");
	kill_change_a: assert property (
		!$stable(o_colour_kill_en) |-> $past(i_avs_write))
		else $error("colour kill changed without write");
	mode_change_a: assert property (
		!$stable(o_luma_gain_mode) |-> $past(i_avs_write))
		else $error("gain mode changed without write");
	clk_group_a: assert property (
		inv_llc == inv_line_locked_clock_half && inv_llc == inv_qualifier_clock)
		else $error("clock outputs disagree in polarity");
	ref_group_a: assert property (inv_horiz_reference == inv_vref)
		else $error("reference outputs disagree in polarity");
	pol_change_a: assert property (
		!$stable(inv_llc) |-> $past(i_avs_write))
		else $error("clock polarity changed without write");
endmodule // lgh_regs_props

// ### verif/tb_top.sv
// self-checking bench for the gain, sync position and polarity registers
`timescale 1ns/1ps
module tb_top;
	logic        clk = 0;    // 25 mhz system clock
	logic        rstn = 0;   // async reset, active low
	logic [7:0]  adr = 0;
	logic        rd = 0;
	logic        wr = 0;
	logic [31:0] wd = 0;
	logic [3:0]  be = 0;
	logic [11:0] agc = 0;
	logic        ls = 0;
	logic        fs = 0;
	logic        pal = 0;
	logic        pix = 0;
	logic        ihs = 1;    // internal sync idles high
	logic [8:0]  ln = 0;
	logic [11:0] raw = 0;    // raw video core outputs
	logic [12:0] pin;        // adjusted pins, hsync on top
	logic [31:0] rdat;
	logic        wt, upd, win, ck;
	logic [11:0] gain;
	logic [7:0]  ire;
	logic [2:0]  mode;
	int          err_count = 0;
	int          compares = 0;
	logic [31:0] expq[$];    // expected read data, oldest first
	logic [7:0]  rst_v[7] = '{8'h70, 8'h00, 8'hE3, 8'h0F, 8'h01, 8'h00,
		8'h00};
	logic [7:0]  pal_t[8] = '{8'h85, 8'h7D, 8'h78, 8'h73, 8'h6E, 8'h69,
		8'h64, 8'h64};
	logic [7:0]  ntsc_t[8] = '{8'h7A, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64,
		8'h64, 8'h64};
	logic [8:0]  lines[6] = '{9'h020, 9'h021, 9'h10E, 9'h10F, 9'h136,
		9'h137};

	lgh_regs i_dut (.i_sys_clk(clk), .i_rstn(rstn),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wt),
		.i_agc_gain(agc), .i_line_start(ls), .i_field_start(fs),
		.i_line_num(ln), .i_pal(pal), .o_luma_gain(gain),
		.o_gain_update(upd), .o_avg_window(win), .o_max_ire(ire),
		.o_colour_kill_en(ck), .o_luma_gain_mode(mode),
		.i_pix_en(pix), .i_int_hsync(ihs),
		.i_line_locked_clock(raw[0]), .i_line_locked_clock_half(raw[1]),
		.i_qualifier_clock(raw[2]), .i_fifo_half_full(raw[3]),
		.i_fifo_almost_empty(raw[4]), .i_fifo_almost_full(raw[5]),
		.i_pol2_src(raw[6]), .i_pol3_src(raw[7]), .i_pol4_src(raw[8]),
		.i_vsync(raw[9]), .i_horiz_reference(raw[10]),
		.i_vert_reference(raw[11]),
		.o_line_locked_clock(pin[0]), .o_line_locked_clock_half(pin[1]),
		.o_qualifier_clock(pin[2]), .o_fifo_half_full(pin[3]),
		.o_fifo_almost_empty(pin[4]), .o_fifo_almost_full(pin[5]),
		.o_pol2_out(pin[6]), .o_pol3_out(pin[7]), .o_pol4_out(pin[8]),
		.o_vsync(pin[9]), .o_horiz_reference(pin[10]),
		.o_vert_reference(pin[11]), .o_hsync(pin[12]));

	// free-running clock
	always #20 clk = ~clk;

	// one comparison; case inequality so an unknown bit matches only an unknown bit
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// read data stands at the edge where waitrequest is seen low
	always @(posedge clk) begin
		if (rd === 1'b1 && wt === 1'b0)
			chk(rdat, expq.pop_front());
	end

	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= {24'($urandom()), d};
		be <= b;
		if (w)
			wr <= 1;
		else
			rd <= 1;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 50);
		wr <= 0;
		rd <= 0;
	endtask

	// read with the expected value noted for the monitor
	task automatic rck(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(0, a, 8'h00, 4'h0);
	endtask

	// polarity bit that governs each raw output
	function automatic int pb(input int i);
		return i < 3 ? 0 : i < 6 ? 1 : i < 9 ? i - 4 : i == 9 ? 5 : 6;
	endfunction

	// prints counts and verdict, ends the run
	task automatic give_verdict;
		$display("mismatches %0d comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the run needs
	initial begin
		#400000;
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		give_verdict;
	end

	initial begin
		logic [11:0] g, a1;
		logic [7:0]  p;
		int          t0, t1;
		g = 12'($urandom(32'hf884));
		repeat (2) @(posedge clk);
		rstn <= 1;
		// reset values, then an unmapped place
		foreach (rst_v[i]) rck(8'h31 + 8'(i), {24'h0, rst_v[i]});
		rck(8'h10, 32'h0);
		// manual gain split across the two shadows
		g = 12'($urandom());
		bus(1, 8'h31, {4'h0, g[11:8]}, 4'h1);
		bus(1, 8'h32, g[7:0], 4'h1);
		bus(1, 8'h32, ~g[7:0], 4'h0);
		rck(8'h32, {24'h0, g[7:0]});
		rck(8'h31, {24'h0, 4'h7, g[11:8]});
		chk(gain, g);
		// automatic mode: store follows the loop only while enabled
		a1 = 12'($urandom());
		bus(1, 8'h38, 8'h05, 4'h1);
		agc <= a1;
		bus(1, 8'h31, 8'h80, 4'h1);
		rck(8'h32, {24'h0, a1[7:0]});
		rck(8'h31, {24'h0, 4'hF, a1[11:8]});
		bus(1, 8'h31, 8'h00, 4'h1);
		agc <= ~a1;
		rck(8'h32, {24'h0, a1[7:0]});
		chk(mode, 3'h5);
		bus(1, 8'h38, 8'h00, 4'h1);
		@(posedge clk);
		@(negedge clk);
		chk(gain, {4'h0, g[7:0]});
		// every ire code for both standards, colour kill toggling
		for (int i = 0; i < 16; i++) begin
			pal <= i[3];
			bus(1, 8'h33, {2'b10 | 2'(i[0]), 1'b1, 3'(i), 2'b00}, 4'h1);
			@(posedge clk);
			@(negedge clk);
			chk(ire, i[3] ? pal_t[i[2:0]] : ntsc_t[i[2:0]]);
			chk(ck, i[0]);
		end
		// update rate and brightness window at the line boundaries
		foreach (lines[j]) for (int b = 0; b < 2; b++) begin
			bus(1, 8'h33, b ? 8'hA3 : 8'hA0, 4'h1);
			ln <= lines[j];
			ls <= 1;
			@(posedge clk);
			ls <= 0;
			fs <= 1;
			@(negedge clk);
			chk(upd, !b);
			@(posedge clk);
			fs <= 0;
			@(negedge clk);
			chk(upd, b);
			chk(win, lines[j] >= 9'h021 &&
				lines[j] <= (b ? 9'h10E : 9'h136));
		end
		// random polarity settings against random raw levels
		repeat (6) begin
			p = 8'($urandom());
			bus(1, 8'h37, p, 4'h1);
			raw <= 12'($urandom());
			@(negedge clk);
			for (int i = 0; i < 12; i++)
				chk(pin[i], raw[i] ^ p[pb(i)]);
			chk(pin[12], p[7]);
			rck(8'h37, {24'h0, p});
		end
		// sync begin 0x104 and end 0x10A, high bits shared
		bus(1, 8'h37, 8'h00, 4'h1);
		bus(1, 8'h34, 8'h5F, 4'h1);
		bus(1, 8'h35, 8'h04, 4'h1);
		bus(1, 8'h36, 8'h0A, 4'h1);
		rck(8'h34, 32'h5F);
		pix <= 1;
		ihs <= 0;
		t0 = 0;
		while (pin[12] !== 1'b1 && t0 < 2000) begin
			@(posedge clk);
			t0++;
		end
		t1 = t0;
		while (pin[12] !== 1'b0 && t1 < 2000) begin
			@(posedge clk);
			t1++;
		end
		chk(t1 - t0, 6);
		chk(t0 >= 260 && t0 <= 263, 1);
		give_verdict;
	end
endmodule // tb_top

bind lgh_regs lgh_regs_props i_props (.*);
